// File: lhp_pkg.sv
// Shared constants and helpers for the display host port
`default_nettype none

package lhp_pkg;

    // Display RAM geometry
    localparam int PAGE_W    = 4;
    localparam int COL_W     = 8;
    localparam int LINE_W    = 7;
    localparam int START_W   = 6;
    localparam int NUM_COLS  = 132;
    localparam int NUM_LINES = 65;
    localparam int NUM_PAGES = 9;
    localparam int RAM_WORDS = NUM_PAGES * NUM_COLS;
    localparam int ADDR_W    = 11;
    localparam int SER_BITS  = 8;

    localparam logic [PAGE_W-1:0] INDICATOR_PAGE = 4'h8;
    localparam logic [COL_W-1:0]  COL_LAST       = 8'h83;

    // Reset values of the settings
    localparam logic [PAGE_W-1:0]  PAGE_RST  = 4'h0;
    localparam logic [COL_W-1:0]   COL_RST   = 8'h00;
    localparam logic [START_W-1:0] START_RST = 6'h00;

    // Command codes and the masks that select their fixed bits
    localparam logic [7:0] CMD_COL_LO     = 8'h00;
    localparam logic [7:0] CMD_COL_HI     = 8'h10;
    localparam logic [7:0] CMD_PAGE       = 8'hB0;
    localparam logic [7:0] MASK_NIBBLE    = 8'hF0;
    localparam logic [7:0] CMD_START      = 8'h40;
    localparam logic [7:0] MASK_START     = 8'hC0;
    localparam logic [7:0] CMD_SEG_DIR    = 8'hA0;
    localparam logic [7:0] CMD_REVERSE    = 8'hA6;
    localparam logic [7:0] CMD_ALL_ON     = 8'hA4;
    localparam logic [7:0] CMD_DISP_ON    = 8'hAE;
    localparam logic [7:0] MASK_BIT0      = 8'hFE;

    // Status byte layout
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_SEG_BIT  = 6;
    localparam int STAT_OFF_BIT  = 5;
    localparam int STAT_RST_BIT  = 4;

    // Pin synchroniser layout and idle levels
    localparam int PIN_W       = 16;
    localparam int PIN_RES_N   = 15;
    localparam int PIN_PAR     = 14;
    localparam int PIN_STYLE   = 13;
    localparam int PIN_CSL_N   = 12;
    localparam int PIN_CSH     = 11;
    localparam int PIN_DC      = 10;
    localparam int PIN_RD      = 9;
    localparam int PIN_WR      = 8;
    localparam int PIN_SDATA   = 7;
    localparam int PIN_SCLK    = 6;
    localparam logic [PIN_W-1:0] PIN_IDLE = 16'h5300;

    // Timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int BUSY_TIME_NS    = 80;
    localparam int BUSY_CYCLES     =
        (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LINE_TIME_NS    = 6400;
    localparam int LINE_CYCLES_DEF = LINE_TIME_NS / CLK_PERIOD_NS;

    // Byte address of a page and column in the display RAM
    function automatic logic [ADDR_W-1:0] ram_index(
        input logic [PAGE_W-1:0] page,
        input logic [COL_W-1:0]  col
    );
        ram_index = ADDR_W'(page) * ADDR_W'(NUM_COLS) + ADDR_W'(col);
    endfunction : ram_index

    // Compare a command byte against a code under a mask
    function automatic logic cmd_is(
        input logic [7:0] value,
        input logic [7:0] code,
        input logic [7:0] mask
    );
        cmd_is = ((value & mask) == code);
    endfunction : cmd_is

endpackage : lhp_pkg

`default_nettype wire

// File: lhp_byte_if.sv
// Byte hand-off from the serial receiver to the port core
`default_nettype none

interface lhp_byte_if;
    logic       valid;
    logic [7:0] data;
    logic       is_data;

    modport src (output valid, output data, output is_data);
    modport dst (input valid, input data, input is_data);
endinterface : lhp_byte_if

`default_nettype wire

// File: lhp_serial_rx.sv
// Write-only serial receiver: shifts eight bits, tags data or command
`default_nettype none

module lhp_serial_rx
    import lhp_pkg::*;
(
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Synchronised link inputs
    input  wire logic   enable,
    input  wire logic   sclk_s,
    input  wire logic   sdata_s,
    input  wire logic   dc_s,
    // Received bytes
    lhp_byte_if.src     out
);

    logic       sclk_d_reg;
    logic [7:0] shift_reg;
    logic [2:0] count_reg;
    logic       valid_reg;
    logic [7:0] data_reg;
    logic       is_data_reg;
    logic       rise;

    // Serial clock edge, seen on the already synchronised level
    assign rise = sclk_s & ~sclk_d_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
        end
    end

    // Shifter, MSB first; cleared whenever the chip is not selected
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            shift_reg <= 8'h00;
            count_reg <= 3'h0;
        end else if (rise) begin
            shift_reg <= {shift_reg[6:0], sdata_s};
            count_reg <= count_reg + 3'h1;
        end
    end

    // Byte complete on the eighth edge; select line sampled there too
    always_ff @(posedge clk) begin
        if (rst) begin
            valid_reg   <= 1'b0;
            data_reg    <= 8'h00;
            is_data_reg <= 1'b0;
        end else begin
            valid_reg <= enable && rise && (count_reg == 3'(SER_BITS - 1));
            if (enable && rise && (count_reg == 3'(SER_BITS - 1))) begin
                data_reg    <= {shift_reg[6:0], sdata_s};
                is_data_reg <= dc_s;
            end
        end
    end

    assign out.valid   = valid_reg;
    assign out.data    = data_reg;
    assign out.is_data = is_data_reg;

endmodule : lhp_serial_rx

`default_nettype wire

// File: lhp_host_port.sv
// Host port, display RAM and line latch of a graphic display driver
`default_nettype none

module lhp_host_port
    import lhp_pkg::*;
#(
    parameter int LINE_CYCLES = LINE_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Host configuration and select pins
    input  wire logic                 reset_n_input,
    input  wire logic                 parallel_serial_select,
    input  wire logic                 bus_style_select,
    input  wire logic                 chip_select_low_n,
    input  wire logic                 chip_select_high,
    input  wire logic                 data_command_select,
    // Strobes: read or enable, write or read-not-write
    input  wire logic                 read_strobe,
    input  wire logic                 write_strobe,
    // Data bus, three signals per line
    input  wire logic [7:0]           data_in,
    output logic      [7:0]           data_out,
    output logic      [7:0]           data_oe_n,
    // Display side
    output logic      [NUM_COLS-1:0]  seg_data,
    output logic      [LINE_W-1:0]    com_line,
    output logic                      line_strobe,
    output logic                      busy
);

    // Refuse line periods that cannot fetch a whole row
    if (LINE_CYCLES < NUM_COLS + 1 || LINE_CYCLES > 256) begin : g_chk
        $error("LINE_CYCLES must lie between 133 and 256");
    end

    // Pin synchroniser: two stages before any logic
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;

    assign pin_raw = {reset_n_input, parallel_serial_select,
                      bus_style_select, chip_select_low_n,
                      chip_select_high, data_command_select,
                      read_strobe, write_strobe, data_in};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_meta_reg <= PIN_IDLE;
            pin_sync_reg <= PIN_IDLE;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Synchronised pin names
    logic       res_n_s;
    logic       par_s;
    logic       style_s;
    logic       dc_s;
    logic       rd_s;
    logic       wr_s;
    logic [7:0] bus_s;
    logic       chip_active;

    assign res_n_s = pin_sync_reg[PIN_RES_N];
    assign par_s   = pin_sync_reg[PIN_PAR];
    assign style_s = pin_sync_reg[PIN_STYLE];
    assign dc_s    = pin_sync_reg[PIN_DC];
    assign rd_s    = pin_sync_reg[PIN_RD];
    assign wr_s    = pin_sync_reg[PIN_WR];
    assign bus_s   = pin_sync_reg[7:0];
    assign chip_active = ~pin_sync_reg[PIN_CSL_N]
                       & pin_sync_reg[PIN_CSH];

    // Previous strobe levels for edge detection
    logic rd_d_reg;
    logic wr_d_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_d_reg <= 1'b1;
            wr_d_reg <= 1'b1;
        end else begin
            rd_d_reg <= rd_s;
            wr_d_reg <= wr_s;
        end
    end

    // Parallel access decode; all gated by chip select
    logic par_on;
    logic e_fall;
    logic par_wr_evt;
    logic par_rd_end;
    logic par_rd_act;

    assign par_on = chip_active & par_s;
    assign e_fall = rd_d_reg & ~rd_s;

    always_comb begin
        if (style_s) begin
            par_wr_evt = par_on & e_fall & ~wr_s;
            par_rd_end = par_on & e_fall & wr_s;
            par_rd_act = par_on & rd_s & wr_s;
        end else begin
            par_wr_evt = par_on & wr_s & ~wr_d_reg;
            par_rd_end = par_on & rd_s & ~rd_d_reg;
            par_rd_act = par_on & ~rd_s;
        end
    end

    // Serial receiver, write only
    lhp_byte_if ser_if ();

    lhp_serial_rx u_serial (
        .clk     (sys_clk),
        .rst     (rst),
        .enable  (chip_active & ~par_s),
        .sclk_s  (pin_sync_reg[PIN_SCLK]),
        .sdata_s (pin_sync_reg[PIN_SDATA]),
        .dc_s    (dc_s),
        .out     (ser_if.dst)
    );

    // Merged write stream from either port
    logic       wr_evt;
    logic [7:0] wr_byte;
    logic       wr_is_data;
    logic       settings_clr;
    logic       cmd_evt;
    logic       data_wr_evt;
    logic       data_rd_evt;

    assign wr_evt      = par_wr_evt | ser_if.valid;
    assign wr_byte     = ser_if.valid ? ser_if.data : bus_s;
    assign wr_is_data  = ser_if.valid ? ser_if.is_data : dc_s;
    assign settings_clr = rst | ~res_n_s;
    assign cmd_evt     = wr_evt & ~wr_is_data & ~busy;
    assign data_wr_evt = wr_evt & wr_is_data;
    assign data_rd_evt = par_rd_end & dc_s;

    // Busy time after each accepted command
    logic [3:0] busy_cnt_reg;

    always_ff @(posedge sys_clk) begin
        if (settings_clr) begin
            busy_cnt_reg <= 4'h0;
        end else if (cmd_evt) begin
            busy_cnt_reg <= 4'(BUSY_CYCLES);
        end else if (busy_cnt_reg != 4'h0) begin
            busy_cnt_reg <= busy_cnt_reg - 4'h1;
        end
    end

    assign busy = settings_clr | (busy_cnt_reg != 4'h0);

    // Settings and address counters
    logic [PAGE_W-1:0]  page_reg;
    logic [COL_W-1:0]   col_reg;
    logic [START_W-1:0] start_line_reg;
    logic               seg_dir_reg;
    logic               reverse_reg;
    logic               all_on_reg;
    logic               disp_on_reg;
    logic [COL_W-1:0]   col_set;

    // Nibble loads saturate so the column never leaves the RAM
    always_comb begin
        if (cmd_is(wr_byte, CMD_COL_HI, MASK_NIBBLE)) begin
            col_set = {wr_byte[3:0], col_reg[3:0]};
        end else begin
            col_set = {col_reg[7:4], wr_byte[3:0]};
        end
        if (col_set > COL_LAST) begin
            col_set = COL_LAST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (settings_clr) begin
            page_reg       <= PAGE_RST;
            col_reg        <= COL_RST;
            start_line_reg <= START_RST;
            seg_dir_reg    <= 1'b0;
            reverse_reg    <= 1'b0;
            all_on_reg     <= 1'b0;
            disp_on_reg    <= 1'b0;
        end else if (cmd_evt) begin
            if (cmd_is(wr_byte, CMD_PAGE, MASK_NIBBLE)) begin
                if (wr_byte[3:0] <= INDICATOR_PAGE) begin
                    page_reg <= wr_byte[3:0];
                end
            end else if (cmd_is(wr_byte, CMD_COL_HI, MASK_NIBBLE) ||
                         cmd_is(wr_byte, CMD_COL_LO, MASK_NIBBLE)) begin
                col_reg <= col_set;
            end else if (cmd_is(wr_byte, CMD_START, MASK_START)) begin
                start_line_reg <= wr_byte[5:0];
            end else if (cmd_is(wr_byte, CMD_SEG_DIR, MASK_BIT0)) begin
                seg_dir_reg <= wr_byte[0];
            end else if (cmd_is(wr_byte, CMD_REVERSE, MASK_BIT0)) begin
                reverse_reg <= wr_byte[0];
            end else if (cmd_is(wr_byte, CMD_ALL_ON, MASK_BIT0)) begin
                all_on_reg <= wr_byte[0];
            end else if (cmd_is(wr_byte, CMD_DISP_ON, MASK_BIT0)) begin
                disp_on_reg <= wr_byte[0];
            end
        end else if ((data_wr_evt || data_rd_evt) && col_reg < COL_LAST) begin
            col_reg <= col_reg + 8'h01;
        end
    end

    // Display RAM: host port plus independent refresh read port
    logic [7:0]        ram_mem [0:RAM_WORDS-1];
    logic [7:0]        holder_reg;
    logic              wr_pend_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [7:0]        wr_masked;

    // Indicator page stores only the lowest bit
    assign wr_masked = (page_reg == INDICATOR_PAGE) ?
                       {7'h00, wr_byte[0]} : wr_byte;

    // Bus holder: written data waits one cycle, reads refill it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            holder_reg  <= 8'h00;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= data_wr_evt;
            if (data_wr_evt) begin
                holder_reg  <= wr_masked;
                wr_addr_reg <= ram_index(page_reg, col_reg);
            end else if (data_rd_evt) begin
                holder_reg <= ram_mem[ram_index(page_reg, col_reg)];
            end
        end
    end

    // Commit from the holder long before the next write may arrive
    always_ff @(posedge sys_clk) begin
        if (wr_pend_reg) begin
            ram_mem[wr_addr_reg] <= holder_reg;
        end
    end

    // Read data: holder contents for data, status otherwise
    logic [7:0] status_byte;
    logic [7:0] data_out_reg;

    always_comb begin
        status_byte = 8'h00;
        status_byte[STAT_BUSY_BIT] = busy;
        status_byte[STAT_SEG_BIT]  = seg_dir_reg;
        status_byte[STAT_OFF_BIT]  = ~disp_on_reg;
        status_byte[STAT_RST_BIT]  = ~res_n_s;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_out_reg <= 8'h00;
        end else begin
            data_out_reg <= dc_s ? holder_reg : status_byte;
        end
    end

    // Drive only for a parallel read of a selected chip
    assign data_out  = data_out_reg;
    assign data_oe_n = {8{~par_rd_act}};

    // Refresh timing: one RAM byte per cycle within the line period
    logic [7:0]        ref_col_reg;
    logic [LINE_W-1:0] line_reg;
    logic [7:0]        row_sum;
    logic [LINE_W-1:0] row_now;
    logic [7:0]        ref_byte;
    logic              line_end;

    assign line_end = (ref_col_reg == 8'(LINE_CYCLES - 1));
    assign row_sum  = {2'h0, start_line_reg} + {1'h0, line_reg};
    assign row_now  = (row_sum >= 8'(NUM_LINES)) ?
                      7'(row_sum - 8'(NUM_LINES)) : row_sum[6:0];
    assign ref_byte = (ref_col_reg < 8'(NUM_COLS)) ?
                      ram_mem[ram_index(row_now[6:3], ref_col_reg)] :
                      8'h00;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ref_col_reg <= 8'h00;
            line_reg    <= '0;
        end else if (line_end) begin
            ref_col_reg <= 8'h00;
            if (line_reg == 7'(NUM_LINES - 1)) begin
                line_reg <= '0;
            end else begin
                line_reg <= line_reg + 7'h01;
            end
        end else begin
            ref_col_reg <= ref_col_reg + 8'h01;
        end
    end

    // Shadow row gathered bit by bit; host never stalls this path
    logic [NUM_COLS-1:0] shadow_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shadow_reg <= '0;
        end else if (ref_col_reg < 8'(NUM_COLS)) begin
            shadow_reg[ref_col_reg] <= ref_byte[row_now[2:0]];
        end
    end

    // Segment mapping and display modes, applied to latch data only
    logic [NUM_COLS-1:0] seg_next;

    for (genvar i = 0; i < NUM_COLS; i++) begin : g_seg
        logic src_bit;
        assign src_bit = seg_dir_reg ? shadow_reg[NUM_COLS-1-i]
                                     : shadow_reg[i];
        assign seg_next[i] = disp_on_reg &
                             (all_on_reg | (src_bit ^ reverse_reg));
    end

    // Output latch, loaded once per line
    logic [NUM_COLS-1:0] seg_latch_reg;
    logic [LINE_W-1:0]   com_line_reg;
    logic                line_strobe_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seg_latch_reg   <= '0;
            com_line_reg    <= '0;
            line_strobe_reg <= 1'b0;
        end else begin
            line_strobe_reg <= line_end;
            if (line_end) begin
                seg_latch_reg <= seg_next;
                com_line_reg  <= row_now;
            end
        end
    end

    assign seg_data    = seg_latch_reg;
    assign com_line    = com_line_reg;
    assign line_strobe = line_strobe_reg;

endmodule : lhp_host_port

`default_nettype wire

// File: lhp_port_monitor.sv
// Port checker for the display host port
`default_nettype none

module lhp_port_monitor
    import lhp_pkg::*;
#(
    parameter int LINE_CYCLES = LINE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                rst,
    // Host pins
    input wire logic                reset_n_input,
    input wire logic                parallel_serial_select,
    input wire logic                chip_select_high,
    input wire logic                data_command_select,
    // Device outputs
    input wire logic [7:0]          data_out,
    input wire logic [7:0]          data_oe_n,
    input wire logic [NUM_COLS-1:0] seg_data,
    input wire logic [LINE_W-1:0]   com_line,
    input wire logic                line_strobe,
    input wire logic                busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [8:0] gap_reg;
    logic       seen_reg;

    // Cycles since last strobe; first gap after reset is unknown
    always_ff @(posedge sys_clk) begin
        if (rst || line_strobe) gap_reg <= 9'h000;
        else gap_reg <= gap_reg + 9'h001;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) seen_reg <= 1'b0;
        else if (line_strobe) seen_reg <= 1'b1;
    end

    property p_desel_release;
        !chip_select_high [*3] |-> data_oe_n == 8'hFF;
    endproperty
    a_desel_release: assert property (p_desel_release)
        else $error("bus driven while deselected");
    property p_serial_release;
        !parallel_serial_select [*3] |-> data_oe_n == 8'hFF;
    endproperty
    a_serial_release: assert property (p_serial_release)
        else $error("bus driven in serial mode");
    property p_reset_busy;
        !reset_n_input [*3] |-> busy;
    endproperty
    a_reset_busy: assert property (p_reset_busy)
        else $error("not busy while reset pin low");
    property p_busy_short;
        reset_n_input [*4] ##0 busy |-> ##[1:2] !busy;
    endproperty
    a_busy_short: assert property (p_busy_short)
        else $error("busy too long");
    property p_status_busy;
        (!data_command_select && !rst) [*4] |->
            data_out[STAT_BUSY_BIT] == $past(busy) && data_out[3:0] == 4'h0;
    endproperty
    a_status_busy: assert property (p_status_busy)
        else $error("status byte wrong");
    property p_line_period;
        line_strobe && seen_reg |-> gap_reg == 9'(LINE_CYCLES - 1);
    endproperty
    a_line_period: assert property (p_line_period)
        else $error("line period wrong");
    property p_line_range;
        com_line < LINE_W'(NUM_LINES);
    endproperty
    a_line_range: assert property (p_line_range)
        else $error("row out of range");
    property p_latch_hold;
        $changed(seg_data) || $changed(com_line) |-> line_strobe;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch changed off the line load");
endmodule : lhp_port_monitor

bind lhp_host_port lhp_port_monitor #(.LINE_CYCLES(LINE_CYCLES)) mon (
    .sys_clk, .rst, .reset_n_input, .parallel_serial_select,
    .chip_select_high, .data_command_select, .data_out, .data_oe_n,
    .seg_data, .com_line, .line_strobe, .busy);

`default_nettype wire

// File: lhp_host_model.sv
// Host processor model: parallel strobes, serial link and bus wire
`default_nettype none

module lhp_host_model (
    // Clock and bus style
    input  wire logic       clk,
    input  wire logic       style,
    // Device side of the bus
    input  wire logic [7:0] data_out,
    input  wire logic [7:0] data_oe_n,
    // Host pins
    output logic            dc,
    output logic            rd,
    output logic            wr,
    output logic [7:0]      data_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] d_reg = 8'h00;
    logic       drv_reg = 1'b0;
    logic       dc_reg = 1'b0;
    logic       e_reg = 1'b0;
    logic       rdn_reg = 1'b1;
    logic       wr_reg = 1'b1;
    logic [7:0] oe_seen = 8'hFF;

    // Released bus shows a flipped ghost, never the last byte
    assign data_in = !data_oe_n[0] ? data_out : drv_reg ? d_reg : ~d_reg;
    assign dc = dc_reg;
    assign rd = style ? e_reg : rdn_reg;
    assign wr = wr_reg;

    // One access of 12 cycles, so busy never needs polling
    task automatic access(input logic rd_op, input logic a0,
                          input logic [7:0] b, output logic [7:0] q);
        @(posedge clk);
        dc_reg <= a0;
        d_reg <= b;
        drv_reg <= !rd_op;
        wr_reg <= rd_op;
        rdn_reg <= !rd_op;
        @(posedge clk);
        e_reg <= 1'b1;
        repeat (5) @(posedge clk);
        q = data_in;
        oe_seen = data_oe_n;
        e_reg <= 1'b0;
        rdn_reg <= 1'b1;
        if (!style) wr_reg <= 1'b1;
        repeat (5) @(posedge clk);
        wr_reg <= 1'b1;
        drv_reg <= 1'b0;
    endtask : access

    // Serial byte MSB first, clock idles low; n below 8 leaves a stub
    task automatic ser_byte(input logic a0, input logic [7:0] b,
                            input int n);
        @(posedge clk);
        drv_reg <= 1'b1;
        dc_reg <= a0;
        d_reg <= 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            repeat (4) @(posedge clk);
            d_reg <= {b[i], 7'h00};
            repeat (4) @(posedge clk);
            d_reg[6] <= 1'b1;
        end
        repeat (4) @(posedge clk);
        d_reg <= 8'h00;
        repeat (4) @(posedge clk);
    endtask : ser_byte
endmodule : lhp_host_model

`default_nettype wire

// File: lcd_host_port_ram_access_test.sv
// Self-checking bench for the display host port
`default_nettype none

module lcd_host_port_ram_access_test
    import lhp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int LC = 133;

    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                res_n = 1'b1;
    logic                par = 1'b1;
    logic                style = 1'b0;
    logic                csl_n = 1'b0;
    logic                csh = 1'b1;
    logic                dc, rd, wr, line_strobe, busy;
    logic [7:0]          data_in, data_out, data_oe_n;
    logic [NUM_COLS-1:0] seg_data;
    logic [LINE_W-1:0]   com_line, l;
    int                  mismatches = 0;
    int                  n_checks = 0;
    logic [7:0]          ser [4] = '{8'hB0, 8'h10, 8'h07, 8'h5A};
    // Row: read, data select, compare flag, byte
    logic [10:0] rows [46] = '{
        11'h0B0, 11'h010, 11'h005, 11'h2A5, 11'h23C, 11'h0B0, 11'h010,
        11'h005, 11'h600, 11'h7A5, 11'h73C, 11'h0B8, 11'h010, 11'h000,
        11'h2FF, 11'h010, 11'h000, 11'h600, 11'h701, 11'h0B1, 11'h018,
        11'h003, 11'h211, 11'h222, 11'h018, 11'h003, 11'h600, 11'h722,
        11'h0AE, 11'h520, 11'h0AF, 11'h0A1, 11'h540, 11'h0A0, 11'h500,
        11'h0B0, 11'h010, 11'h005, 11'h600, 11'h7A5, 11'h0B0, 11'h010,
        11'h007, 11'h600, 11'h75A, 11'h796};

    lhp_host_port #(.LINE_CYCLES(LC)) dut (.sys_clk(clk), .rst(rst),
        .reset_n_input(res_n), .parallel_serial_select(par),
        .bus_style_select(style), .chip_select_low_n(csl_n),
        .chip_select_high(csh), .data_command_select(dc),
        .read_strobe(rd), .write_strobe(wr), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .seg_data(seg_data),
        .com_line(com_line), .line_strobe(line_strobe), .busy(busy));

    lhp_host_model host (.clk(clk), .style(style), .data_out(data_out),
        .data_oe_n(data_oe_n), .dc(dc), .rd(rd), .wr(wr), .data_in(data_in));

    // Free-running system clock
    always #20 clk = ~clk;

    task automatic check(input logic [NUM_COLS-1:0] seen,
                         input logic [NUM_COLS-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask : check

    task automatic do_row(input logic [10:0] r);
        logic [7:0] q;
        host.access(r[10], r[9], r[7:0], q);
        if (r[8]) check(q, r[7:0]);
    endtask : do_row

    task automatic run(input int lo, input int hi);
        for (int i = lo; i < hi; i++) do_row(rows[i]);
    endtask : run

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // Main sequence: table in both bus styles, then awkward cases
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        for (int s = 0; s < 2; s++) begin
            style <= s[0];
            run(0, 35);
            $display("table pass %0d done", s);
        end
        style <= 1'b0;
        csh <= 1'b0;
        do_row(11'h277);
        csh <= 1'b1;
        csl_n <= 1'b1;
        do_row(11'h600);
        check(host.oe_seen, 8'hFF);
        csl_n <= 1'b0;
        run(35, 40);
        $display("deselect test done");
        par <= 1'b0;
        for (int i = 0; i < 4; i++) host.ser_byte(i == 3, ser[i], 8);
        host.ser_byte(1'b1, 8'hC3, 3);
        csh <= 1'b0;
        repeat (4) @(posedge clk);
        csh <= 1'b1;
        host.ser_byte(1'b1, 8'h96, 8);
        par <= 1'b1;
        run(40, 46);
        $display("serial test done");
        do_row(11'h0A1);
        do_row(11'h0AF);
        res_n <= 1'b0;
        repeat (4) @(posedge clk);
        check(busy, 1'b1);
        res_n <= 1'b1;
        do_row(11'h520);
        $display("reset pin test done");
        do_row(11'h0AF);
        do_row(11'h0A5);
        repeat (2 * LC + 2) @(posedge clk);
        check(seg_data, '1);
        do_row(11'h0A4);
        do_row(11'h0AE);
        repeat (2 * LC + 2) @(posedge clk);
        check(seg_data, '0);
        run(35, 40);
        @(posedge clk iff line_strobe);
        l = com_line;
        repeat (LC) @(posedge clk);
        check(com_line, (l + 7'd1) % 7'd65);
        $display("display test done");
        give_verdict();
    end

    // Watchdog: the run needs about 2400 cycles
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
endmodule : lcd_host_port_ram_access_test

`default_nettype wire
